// ---- design/ddr_sdram_cmd_data_port.sv ----
`timescale 1ns/10ps
// Function
// - Commands registered on positive clock edge only
// - Write data on both strobe edges; DDR reads
// - Device drives strobe on reads only
// - Read strobe edges coincide with data edges
// - Activate opens row; read/write picks column
// - Bursts of 2, 4 or 8 locations
// - Auto precharge closes row after burst unless a read/write restarts the burst
// - Four independent banks
// - Clock gate low enters power-down or self-refresh
// - Self-refresh exit is asynchronous on clock gate
// - Inputs disabled in power-down and self-refresh
// - Chip select high masks the command
// - Command decoded from four strobe levels
// - Masked write beats are discarded
// - Bank inputs pick bank or mode register
// - Address carries row, column, flag, op-code
// - Address bit 10 selects precharge all
// - One double word per clock at array
// - Read latency 2, 2.5 or 3 clocks
// - Output path valid only with loop enabled
// - Mode load with bank zero writes mode
// - Burst length codes 001, 010, 011
// - Latency codes 010, 101, 011
module ddr_sdram_cmd_data_port
  import ddr_port_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, high
  input wire logic diff_clk_true, // Memory clock from controller
  input wire logic cke, // Clock gate
  input wire cmd_pins_t cmd, // Command strobes
  input wire logic array_group_sel_0, // Bank select bit 0
  input wire logic array_group_sel_1, // Bank select bit 1
  input wire logic [ADDR_W-1:0] addr, // Address pins
  input wire logic [DQ_W-1:0] dq_i, // Data pin level
  output logic [DQ_W-1:0] dq_o, // Data pin drive value
  output logic dq_oe, // Data pin enable
  input wire logic dqs_i, // Strobe pin level
  output logic dqs_o, // Strobe drive value
  output logic dqs_oe, // Strobe enable
  input wire logic write_byte_mask, // Write beat mask
  output status_t status, // State seen on clk
  output logic refresh_pulse // One clk per refresh
);

  typedef enum logic [2:0] {
    PS_RUN = 3'b001,
    PS_PD_PRE = 3'b010,
    PS_PD_ACT = 3'b100
  } pwr_state_t;

  logic lrst_meta_ff, lrst_ff;
  pwr_state_t pwr_ff, nxt_pwr;
  logic sr_ff;
  logic [BANKS-1:0] open_ff;
  logic [ADDR_W-1:0] row_ff [BANKS];
  logic [ADDR_W-1:0] mode_ff, ext_ff;
  logic [15:0] mem [MEM_DEPTH];
  logic busy_ff, wr_ff, ap_ff, btype_ff;
  logic [BANK_W-1:0] eng_bank_ff;
  logic [ROW_KEEP_W-1:0] eng_row_ff;
  logic [COL_WORD_W-1:0] start_ff;
  logic [1:0] cnt_ff, wmask_ff;
  logic wq_v_ff;
  logic [MEM_AW-1:0] wq_addr_ff;
  logic [DQ_W-1:0] rise_beat_ff, fall_beat_ff;
  logic rise_mask_ff, fall_mask_ff;
  rd_word_t w1_ff, w2_ff, hold_ff;
  logic [DQ_W-1:0] p_dq_ff, n_dq_ff;
  logic p_dqs_ff, n_dqs_ff, p_oe_ff, n_oe_ff;
  logic ref_tgl_ff;
  logic [6:0] st_meta_ff, st_sync_ff;
  logic [2:0] ref_sync_ff;

  // Reset carried into the link domain
  always_ff @(posedge diff_clk_true)
  begin
    lrst_meta_ff <= srst;
    lrst_ff <= lrst_meta_ff;
  end

  // Command decode at the positive edge; inputs gated when asleep
  wire [3:0] cmd_code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
  wire awake = cke && (pwr_ff == PS_RUN) && !sr_ff;
  wire [BANK_W-1:0] bank = {array_group_sel_1, array_group_sel_0};
  wire is_act = awake && (cmd_code == CMD_ACT);
  wire is_rd = awake && (cmd_code == CMD_RD);
  wire is_wr = awake && (cmd_code == CMD_WR);
  wire is_pre = awake && (cmd_code == CMD_PRE);
  wire is_ref = awake && (cmd_code == CMD_REF);
  wire is_mode = awake && (cmd_code == CMD_MODE);
  wire is_rw = is_rd || is_wr;
  wire precharge_all_flag = addr[PRE_ALL_BIT];
  wire all_idle = (open_ff == '0);

  // Mode fields
  wire [2:0] burst_len_field = mode_ff[BLEN_LSB +: 3];
  wire [2:0] read_latency_field = mode_ff[LAT_LSB +: 3];
  wire dll_on = !ext_ff[EXT_DLL_OFF_BIT];
  wire [1:0] wmask_sel = (burst_len_field == BLEN_8) ? WMASK_8 :
                         (burst_len_field == BLEN_4) ? WMASK_4 : WMASK_2;
  wire lat_half = (read_latency_field == LAT_25);
  wire lat_three = (read_latency_field == LAT_3);

  // Power state: sampled clock gate for entry and exit
  wire sr_entry = !cke && (pwr_ff == PS_RUN) && !sr_ff
                  && (cmd_code == CMD_REF);
  always_comb
  begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      PS_RUN:
        if (!cke && !sr_ff && !sr_entry)
          nxt_pwr = all_idle ? PS_PD_PRE : PS_PD_ACT;
      PS_PD_PRE, PS_PD_ACT:
        if (cke)
          nxt_pwr = PS_RUN;
    endcase
  end

  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
      pwr_ff <= PS_RUN;
    else
      pwr_ff <= nxt_pwr;
  end

  // Self refresh: clock gate high leaves it with no clock edge
  always_ff @(posedge diff_clk_true or posedge cke)
  begin
    if (cke)
      sr_ff <= 1'b0;
    else if (lrst_ff)
      sr_ff <= 1'b0;
    else if (sr_entry)
      sr_ff <= 1'b1;
  end

  // Burst engine position
  wire last_word = busy_ff && (cnt_ff == wmask_ff);
  wire ap_done = last_word && ap_ff && !is_rw;
  wire [1:0] off = btype_ff ? (start_ff[1:0] ^ cnt_ff)
                            : (start_ff[1:0] + cnt_ff);
  wire [1:0] low = (start_ff[1:0] & ~wmask_ff) | (off & wmask_ff);
  wire [MEM_AW-1:0] word_addr = {eng_bank_ff, eng_row_ff,
                                 start_ff[COL_WORD_W-1:2], low};

  // Per-bank open row tracking
  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      wire act_hit = is_act && (bank == b[BANK_W-1:0]);
      wire pre_hit = is_pre && (precharge_all_flag
                     || bank == b[BANK_W-1:0]);
      wire ap_hit = ap_done && (eng_bank_ff == b[BANK_W-1:0]);
      always_ff @(posedge diff_clk_true)
      begin
        if (lrst_ff)
          open_ff[b] <= 1'b0;
        else if (act_hit)
          open_ff[b] <= 1'b1;
        else if (pre_hit || ap_hit)
          open_ff[b] <= 1'b0;
      end
      always_ff @(posedge diff_clk_true)
      begin
        if (lrst_ff)
          row_ff[b] <= '0;
        else if (act_hit)
          row_ff[b] <= addr;
      end
    end
  endgenerate

  // Mode and extended mode registers
  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
    begin
      mode_ff <= MODE_RST;
      ext_ff <= EXT_RST;
    end
    else if (is_mode && bank == SEL_MODE)
      mode_ff <= addr;
    else if (is_mode && bank == SEL_EXT)
      ext_ff <= addr;
  end

  // Burst engine: one word per clock, restarted by a new command
  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
      busy_ff <= 1'b0;
    else if (is_rw)
      busy_ff <= 1'b1;
    else if (last_word)
      busy_ff <= 1'b0;
  end

  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
      cnt_ff <= '0;
    else if (is_rw)
      cnt_ff <= '0;
    else if (busy_ff)
      cnt_ff <= cnt_ff + 2'h1;
  end

  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
    begin
      wr_ff <= 1'b0;
      ap_ff <= 1'b0;
      btype_ff <= 1'b0;
      eng_bank_ff <= '0;
      eng_row_ff <= '0;
      start_ff <= '0;
      wmask_ff <= WMASK_2;
    end
    else if (is_rw)
    begin
      wr_ff <= is_wr;
      ap_ff <= addr[PRE_ALL_BIT];
      btype_ff <= mode_ff[BTYPE_BIT];
      eng_bank_ff <= bank;
      eng_row_ff <= row_ff[bank][ROW_KEEP_W-1:0];
      start_ff <= addr[COL_LSB +: COL_WORD_W];
      wmask_ff <= wmask_sel;
    end
  end

  // Write beats captured on both strobe edges
  always_ff @(posedge dqs_i)
  begin
    rise_beat_ff <= dq_i;
    rise_mask_ff <= write_byte_mask;
  end

  always_ff @(negedge dqs_i)
  begin
    fall_beat_ff <= dq_i;
    fall_mask_ff <= write_byte_mask;
  end

  // Write word address lags one clock behind the engine
  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
    begin
      wq_v_ff <= 1'b0;
      wq_addr_ff <= '0;
    end
    else
    begin
      wq_v_ff <= busy_ff && wr_ff;
      wq_addr_ff <= word_addr;
    end
  end

  // Array: one double-width word per clock, beats masked per lane
  always_ff @(posedge diff_clk_true)
  begin
    if (wq_v_ff && !rise_mask_ff)
      mem[wq_addr_ff][DQ_W-1:0] <= rise_beat_ff;
    if (wq_v_ff && !fall_mask_ff)
      mem[wq_addr_ff][2*DQ_W-1:DQ_W] <= fall_beat_ff;
  end

  // Read pipeline; second stage serves latency three
  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
    begin
      w1_ff <= '0;
      w2_ff <= '0;
    end
    else
    begin
      w1_ff.v <= busy_ff && !wr_ff && dll_on;
      w1_ff.rise <= mem[word_addr][DQ_W-1:0];
      w1_ff.fall <= mem[word_addr][2*DQ_W-1:DQ_W];
      w2_ff <= w1_ff;
    end
  end

  // Output beat selection for the two half cycles
  wire rd_word_t src = lat_three ? w2_ff : w1_ff;
  wire [DQ_W-1:0] p_dq_val = lat_half ? hold_ff.fall : src.rise;
  wire p_oe_val = lat_half ? hold_ff.v : src.v;
  wire p_dqs_val = !lat_half;
  wire [DQ_W-1:0] n_dq_val = lat_half ? hold_ff.rise : hold_ff.fall;

  // Rising half: pair of flops combined by exclusive-or
  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
    begin
      hold_ff <= '0;
      p_dq_ff <= '0;
      p_dqs_ff <= 1'b0;
      p_oe_ff <= 1'b0;
    end
    else
    begin
      hold_ff <= src;
      p_dq_ff <= p_dq_val ^ n_dq_ff;
      p_dqs_ff <= p_dqs_val ^ n_dqs_ff;
      p_oe_ff <= p_oe_val ^ n_oe_ff;
    end
  end

  // Falling half of each read beat pair
  always_ff @(negedge diff_clk_true)
  begin
    if (lrst_ff)
    begin
      n_dq_ff <= '0;
      n_dqs_ff <= 1'b0;
      n_oe_ff <= 1'b0;
    end
    else
    begin
      n_dq_ff <= n_dq_val ^ p_dq_ff;
      n_dqs_ff <= lat_half ^ p_dqs_ff;
      n_oe_ff <= hold_ff.v ^ p_oe_ff;
    end
  end

  // Pin drive: strobe edges sit on data edges
  assign dq_o = p_dq_ff ^ n_dq_ff;
  assign dqs_o = p_dqs_ff ^ n_dqs_ff;
  assign dq_oe = p_oe_ff ^ n_oe_ff;
  assign dqs_oe = p_oe_ff ^ n_oe_ff;

  // Refresh event as a toggle for the system side
  always_ff @(posedge diff_clk_true)
  begin
    if (lrst_ff)
      ref_tgl_ff <= 1'b0;
    else if (is_ref)
      ref_tgl_ff <= !ref_tgl_ff;
  end

  // Status levels cross with two flops each
  wire status_t st_link = '{bank_open: open_ff,
                            in_power_down: pwr_ff != PS_RUN,
                            in_self_refresh: sr_ff,
                            dll_on: dll_on};
  always_ff @(posedge clk)
  begin
    st_meta_ff <= st_link;
    st_sync_ff <= st_meta_ff;
    ref_sync_ff <= {ref_sync_ff[1:0], ref_tgl_ff};
  end

  // System-side outputs, cleared under reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status <= '0;
      refresh_pulse <= 1'b0;
    end
    else
    begin
      status <= st_sync_ff;
      refresh_pulse <= ref_sync_ff[2] ^ ref_sync_ff[1];
    end
  end

  // Checks in the link domain
  default clocking @(posedge diff_clk_true); endclocking
  default disable iff (lrst_ff);

  chk_cs_masks_cmd: assert property (
    cmd.cs_n && !ap_done |=> $stable(open_ff))
    else $error("bank state changed on deselect");

  chk_act_opens: assert property (
    is_act |=> open_ff[$past(bank)])
    else $error("activate did not open bank");

  chk_pre_all: assert property (
    is_pre && precharge_all_flag && !is_act |=> all_idle)
    else $error("precharge all left a bank open");

  chk_pre_one: assert property (
    is_pre && !precharge_all_flag && !ap_done
    |=> !open_ff[$past(bank)] && open_ff == ($past(open_ff) &
        ~({{(BANKS-1){1'b0}}, 1'b1} << $past(bank))))
    else $error("single precharge touched other banks");

  chk_mode_load: assert property (
    is_mode && bank == SEL_MODE ##1 !is_mode[*3]
    |-> mode_ff == $past(addr, 3))
    else $error("mode register not kept");

  chk_burst_span: assert property (
    is_rw && wmask_sel == WMASK_8 ##1 !is_rw[*4] |=> !busy_ff)
    else $error("burst of eight wrong length");

  chk_ap_closes: assert property (
    ap_done |=> !open_ff[$past(eng_bank_ff)])
    else $error("auto precharge left row open");

  chk_pd_entry: assert property (
    pwr_ff == PS_RUN && !sr_ff && !cke && cmd_code != CMD_REF
    |=> pwr_ff == ($past(all_idle) ? PS_PD_PRE : PS_PD_ACT))
    else $error("wrong power-down state");

  chk_read_lat2: assert property (
    is_rd && read_latency_field == LAT_2 && dll_on
    ##1 !is_rw |-> ##1 src.v)
    else $error("read data not ready for latency two");

  cov_read_burst: cover property (is_rd ##1 busy_ff ##1 w1_ff.v);
  cov_write_burst: cover property (is_wr ##2 wq_v_ff);
  cov_self_ref: cover property (sr_entry ##1 sr_ff);
  cov_active_pd: cover property (pwr_ff == PS_PD_ACT);

endmodule

// ---- design/ddr_port_pkg.sv ----
package ddr_port_pkg;

  // Pin widths and array geometry
  localparam int DQ_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_KEEP_W = 2;
  localparam int COL_WORD_W = 9;
  localparam int MEM_AW = BANK_W + ROW_KEEP_W + COL_WORD_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // Command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MODE = 4'h0;

  // Address bit positions
  localparam int COL_LSB = 1;
  localparam int PRE_ALL_BIT = 10;
  localparam int BLEN_LSB = 0;
  localparam int BTYPE_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int EXT_DLL_OFF_BIT = 0;

  // Mode field codes
  localparam logic [2:0] BLEN_2 = 3'h1;
  localparam logic [2:0] BLEN_4 = 3'h2;
  localparam logic [2:0] BLEN_8 = 3'h3;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_25 = 3'h5;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;

  // Burst word masks (words per burst minus one)
  localparam logic [1:0] WMASK_2 = 2'h0;
  localparam logic [1:0] WMASK_4 = 2'h1;
  localparam logic [1:0] WMASK_8 = 2'h3;

  // Reset values
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0021;
  localparam logic [ADDR_W-1:0] EXT_RST = 13'h0000;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_t;

  typedef struct packed {
    logic [BANKS-1:0] bank_open;
    logic in_power_down;
    logic in_self_refresh;
    logic dll_on;
  } status_t;

  typedef struct packed {
    logic v;
    logic [DQ_W-1:0] rise;
    logic [DQ_W-1:0] fall;
  } rd_word_t;

endpackage

// ---- tb/ddr_ctrl_model.sv ----
`timescale 1ns/10ps
module ddr_ctrl_model
  import ddr_port_pkg::*;
(
  input wire logic lclk, // Memory clock
  output logic cke, // Clock gate
  output cmd_pins_t cmd, // Command strobes
  output logic [1:0] bank, // Bank select pair
  output logic [ADDR_W-1:0] addr, // Address pins
  output logic [DQ_W-1:0] dq, // Data drive
  output logic dqs, // Strobe drive
  output logic dm // Write beat mask
);
  // Idle pins at time zero
  initial
  begin
    cke = 1'b1;
    cmd = CMD_NOP;
    bank = 2'h0;
    addr = 13'h0000;
    dq = 8'h00;
    dqs = 1'b0;
    dm = 1'b0;
  end

  // One command sampled at the second rising edge, then no-operation
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
    input logic [ADDR_W-1:0] a);
    @(posedge lclk);
    #2;
    cmd = c;
    bank = b;
    addr = a;
    @(posedge lclk);
    #2;
    cmd = CMD_NOP;
    bank = ~b;
    addr = ~a; // Released lines show the inverse
  endtask

  // Two write beats, strobe edges centred in each beat
  task automatic write2(input logic [15:0] w, input logic [1:0] m);
    #118;
    dq = w[7:0];
    dm = m[0];
    #40;
    dqs = 1'b1;
    #40;
    dq = w[15:8];
    dm = m[1];
    #40;
    dqs = 1'b0; // Parked low: any edge would clock a beat
    #40;
    dq = ~dq;
    dm = ~dm;
  endtask

  // Clock gate change with a command at the same edge
  task automatic gate(input logic v, input logic [3:0] c);
    @(posedge lclk);
    #2;
    cke = v;
    cmd = c;
    @(posedge lclk);
    #2;
    cmd = CMD_NOP;
  endtask

  // Self refresh exit off any edge
  task automatic wake();
    #37;
    cke = 1'b1;
  endtask
endmodule

// ---- tb/ddr_sdram_cmd_data_port_test.sv ----
`timescale 1ns/10ps
module ddr_sdram_cmd_data_port_test
  import ddr_port_pkg::*;
();
  localparam logic [2:0] LATS [3] = '{LAT_2, LAT_25, LAT_3};
  localparam int HALVES [3] = '{4, 5, 6};
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic srst = 1'b1;
  logic cke, c_dqs, dm, dq_oe, dqs_i, dqs_o, dqs_oe, refresh_pulse, got;
  cmd_pins_t cmd;
  logic [1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] c_dq, dq_i, dq_o;
  status_t status;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;

  // Clocks: link clock offset so phases never line up
  always #10 clk = ~clk;
  initial
  begin
    #7.3;
    forever #80 lclk = ~lclk;
  end

  // Pin resolution between device and controller
  assign dq_i = dq_oe ? dq_o : c_dq;
  assign dqs_i = dqs_oe ? dqs_o : c_dqs;

  ddr_sdram_cmd_data_port i_dut (.clk(clk), .srst(srst),
    .diff_clk_true(lclk), .cke(cke), .cmd(cmd),
    .array_group_sel_0(bank[0]), .array_group_sel_1(bank[1]),
    .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
    .write_byte_mask(dm), .status(status),
    .refresh_pulse(refresh_pulse));

  ddr_ctrl_model i_ctrl (.lclk(lclk), .cke(cke), .cmd(cmd), .bank(bank),
    .addr(addr), .dq(c_dq), .dqs(c_dqs), .dm(dm));

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Sample the middle of each read beat
  task automatic rd(input int lh, input int n, input logic [63:0] exp);
    #(lh * 80 + 38);
    for (int i = 0; i < n; i++)
    begin
      chk("read data", dq_o, exp[8*i +: 8]);
      chk("strobe", {dqs_oe, dqs_o}, {1'b1, ~i[0]});
      #80;
    end
    chk("drive off", dq_oe, 1'b0);
  endtask

  // No drive may appear for several clocks
  task automatic quiet();
    repeat (8)
    begin
      #80;
      chk("no drive", dq_oe, 1'b0);
    end
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  initial
  begin
    // Reset spans four link edges as well as clk edges
    repeat (4) @(posedge lclk);
    @(posedge clk);
    #2;
    srst = 1'b0;
    repeat (4) @(posedge lclk);
    i_ctrl.issue(CMD_ACT, 2'h1, 13'h0005);
    #300;
    chk("open banks", status.bank_open, 4'h2);
    i_ctrl.issue(CMD_WR, 2'h1, 13'h0004);
    i_ctrl.write2(16'hA55A, 2'h0);
    i_ctrl.issue(CMD_WR, 2'h1, 13'h0006);
    i_ctrl.write2(16'h3CC3, 2'h0);
    i_ctrl.issue(CMD_WR, 2'h1, 13'h0006);
    i_ctrl.write2(16'h7E81, 2'h2);
    done("write");
    // Every latency code, burst of two
    for (int k = 0; k < 3; k++)
    begin
      i_ctrl.issue(CMD_MODE, SEL_MODE, {6'h00, LATS[k], 1'b0, BLEN_2});
      i_ctrl.issue(CMD_RD, 2'h1, 13'h0004);
      rd(HALVES[k], 2, 64'h0000_0000_0000_A55A);
    end
    done("latency");
    i_ctrl.issue(4'hD, 2'h1, 13'h0004);
    quiet();
    i_ctrl.issue(CMD_MODE, SEL_EXT, 13'h0001);
    i_ctrl.issue(CMD_RD, 2'h1, 13'h0004);
    quiet();
    i_ctrl.issue(CMD_MODE, SEL_EXT, 13'h0000);
    done("masked");
    // Burst of four with auto precharge
    i_ctrl.issue(CMD_MODE, SEL_MODE, {6'h00, LAT_2, 1'b0, BLEN_4});
    i_ctrl.issue(CMD_RD, 2'h1, 13'h0404);
    rd(4, 4, 64'h0000_0000_3C81_A55A);
    chk("auto close", status.bank_open, 4'h0);
    done("burst");
    i_ctrl.issue(CMD_ACT, 2'h0, 13'h0001);
    i_ctrl.issue(CMD_ACT, 2'h3, 13'h0002);
    #300;
    chk("two open", status.bank_open, 4'h9);
    i_ctrl.issue(CMD_PRE, 2'h0, 13'h0000);
    #300;
    chk("one closed", status.bank_open, 4'h8);
    i_ctrl.issue(CMD_PRE, 2'h0, 13'h0400);
    #300;
    chk("all closed", status.bank_open, 4'h0);
    done("precharge");
    i_ctrl.issue(CMD_REF, 2'h0, 13'h0000);
    got = 1'b0;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      got = got | (refresh_pulse === 1'b1);
    end
    chk("refresh", got, 1'b1);
    done("refresh");
    i_ctrl.gate(1'b0, CMD_NOP);
    #300;
    chk("power down", status.in_power_down, 1'b1);
    i_ctrl.gate(1'b1, CMD_NOP);
    #300;
    chk("power up", status.in_power_down, 1'b0);
    i_ctrl.gate(1'b0, CMD_REF);
    #300;
    chk("self refresh", status.in_self_refresh, 1'b1);
    i_ctrl.wake();
    #300;
    chk("self exit", status.in_self_refresh, 1'b0);
    done("power");
    end_sim();
  end
endmodule
